// [inc/irq_params_params.svh]
// Register map, field positions, encodings and reset values of the
// interrupt priority and sense block.
// Assumes an APB slave with byte addresses and one register per word.
`ifndef IRQ_PARAMS_PARAMS_SVH
`define IRQ_PARAMS_PARAMS_SVH

// Register byte addresses
`define IPS_ADDR_W 8
`define IPS_OFS_SYS_CTL 8'h00
`define IPS_OFS_PRIO_A 8'h04
`define IPS_OFS_PRIO_B 8'h08
`define IPS_OFS_PRIO_C 8'h0C
`define IPS_OFS_EXT_EN 8'h10
`define IPS_OFS_SENSE 8'h14
`define IPS_OFS_FLAGS 8'h18

// Reset values
`define IPS_RST_SYS_CTL 8'h01
`define IPS_RST_BYTE 8'h00
`define IPS_RST_SENSE 16'h0000

// System control fields
`define IPS_SYS_WMASK 8'hB9
`define IPS_SYS_MODE_HI 5
`define IPS_SYS_MODE_LO 4
`define IPS_SYS_NMI_EDGE 3
`define IPS_MODE_PLAIN 2'h0
`define IPS_MODE_PRIO 2'h1

// Priority A fields
`define IPS_PA_IRQ0 7
`define IPS_PA_IRQ1 6
`define IPS_PA_IRQ23 5
`define IPS_PA_IRQ45 4
`define IPS_PA_IRQ67 3
`define IPS_PA_XFER 2
`define IPS_PA_WDOG 1
// Priority B fields
`define IPS_PB_ADC 6
`define IPS_PB_PT0 5
`define IPS_PB_PT1 4
`define IPS_PB_PT2 3
// Priority C fields
`define IPS_PC_TMR0 7
`define IPS_PC_TMR1 6
`define IPS_PC_SER0 4
`define IPS_PC_SER1 3
`define IPS_PC_SER2 2

// Peripheral source count and order: xfer, wdog, adc, pt0..2, tmr0..1, ser0..2
`define IPS_NUM_PERIPH 11

`endif

// [inc/irq_prio_pkg.sv]
// Types shared by the interrupt priority and sense block.
// Assumes irq_params_params.svh supplies the numeric constants.
package irq_prio_pkg;

  // Interrupt control mode as decoded from the mode field
  typedef enum logic {CTL_PLAIN, CTL_PRIORITY} ctl_mode_t;

  typedef logic [7:0] byte_t;

endpackage

// [rtl/irq_priority_sense_control.sv]
// Interrupt controller register logic: control mode, NMI edge, priority
// levels, external request enables, sense selection and request flags.
// Assumes an APB master on clk, asynchronous pins for NMI, IRQ and standby,
// and CPU / transfer-controller handshakes on clk.
//
// The address map and the APB slave port were chosen for this implementation.
`include "irq_params_params.svh"

// Function
// - System control resets to 01 on reset and hardware standby.
// - Mode field 00: maskable requests gated by CPU mask bit only.
// - Mode 01 uses mask, user mask and priority; 10/11 never written.
// - NMI edge select 0 requests NMI on falling edge, reset value.
// - NMI edge select 1 requests NMI on rising edge.
// - Priority bit set gives level 1, clear gives level 0.
// - All three priority registers clear to 00 on reset and standby.
// - Priority A bits map IRQ0, IRQ1, pairs, transfer controller, watchdog.
// - Priority B and C bits map ADC, pulse timers, 8-bit timers, serial.
// - Enable bit n enables external input n; register resets to 00.
// - Two-bit sense field: low level, falling, rising, both edges.
// - Sense select clears to 0000 on reset and hardware standby.
// - Low-level sensing sets flag n while input n is low.
// - Edge sensing sets flag n on the selected edge.
// - Flag cleared by reading 1 then writing 0; writing 1 keeps it.
// - Low-level mode: exception handling clears flag if input high.
// - Edge mode: exception handling clears flag.
// - Transfer controller activation with select bit 0 clears flag.
// - Flag register clears to 00 on reset and hardware standby.
// - Flags set regardless of the enable bits.
// - NMI is always accepted regardless of CPU mask bits.
module irq_priority_sense_control
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`IPS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins, asynchronous
  input wire logic nmiPin,
  input wire logic [7:0] irqPin_n,
  input wire logic hwStandby,
  // CPU mask state and exception handling
  input wire logic cpuIMask,
  input wire logic cpuUserMask,
  input wire logic irqAck,
  input wire logic [2:0] irqAckNum,
  // Transfer controller activation
  input wire logic xferAct,
  input wire logic [2:0] xferActNum,
  input wire logic xferIntSelect,
  // Peripheral requests
  input wire logic [`IPS_NUM_PERIPH-1:0] periphReq,
  // Toward arbitration
  output logic nmiReq,
  output logic [7:0] extReq,
  output logic [7:0] extLevel,
  output logic [7:0] extAccept,
  output logic [`IPS_NUM_PERIPH-1:0] periphLevel,
  output logic [`IPS_NUM_PERIPH-1:0] periphAccept,
  output logic ctlMode
);

  localparam int NP = `IPS_NUM_PERIPH;

  // Registers
  irq_prio_pkg::byte_t sysCtl_ff;
  irq_prio_pkg::byte_t prioA_ff;
  irq_prio_pkg::byte_t prioB_ff;
  irq_prio_pkg::byte_t prioC_ff;
  irq_prio_pkg::byte_t extEn_ff;
  logic [15:0] sense_ff;
  irq_prio_pkg::byte_t flags_ff;
  irq_prio_pkg::byte_t nxt_flags;
  irq_prio_pkg::byte_t readSeen_ff;
  irq_prio_pkg::ctl_mode_t mode;

  // Synchronisers and edge history
  logic nmiSync1_ff;
  logic nmiSync2_ff;
  logic nmiPrev_ff;
  logic [7:0] irqSync1_ff;
  logic [7:0] irqSync2_ff;
  logic [7:0] irqPrev_ff;
  logic stbySync1_ff;
  logic stbySync2_ff;

  // Bus and derived vectors
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic setupRd;
  logic wrEn;
  logic rdDone;
  logic mapped;
  logic [31:0] rdMux;
  logic [7:0] levelMask;
  logic [7:0] levelSet;
  logic [7:0] edgeSet;
  logic [7:0] ackVec;
  logic [7:0] xferVec;
  logic [7:0] swClr;
  logic [7:0] clrVec;
  logic [7:0] extLvl;
  logic [NP-1:0] perLvl;
  logic [7:0] passExt;
  logic [NP-1:0] passPer;

  // Outputs straight from flip-flops
  logic nmiReq_ff;
  logic [7:0] extReq_ff;
  logic [7:0] extLevel_ff;
  logic [7:0] extAccept_ff;
  logic [NP-1:0] periphLevel_ff;
  logic [NP-1:0] periphAccept_ff;
  logic ctlMode_ff;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign nmiReq = nmiReq_ff;
  assign extReq = extReq_ff;
  assign extLevel = extLevel_ff;
  assign extAccept = extAccept_ff;
  assign periphLevel = periphLevel_ff;
  assign periphAccept = periphAccept_ff;
  assign ctlMode = ctlMode_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nmiSync1_ff <= 1'b1;
      nmiSync2_ff <= 1'b1;
      nmiPrev_ff <= 1'b1;
      irqSync1_ff <= 8'hFF;
      irqSync2_ff <= 8'hFF;
      irqPrev_ff <= 8'hFF;
      stbySync1_ff <= 1'b0;
      stbySync2_ff <= 1'b0;
    end
    else
    begin
      nmiSync1_ff <= nmiPin;
      nmiSync2_ff <= nmiSync1_ff;
      nmiPrev_ff <= nmiSync2_ff;
      irqSync1_ff <= irqPin_n;
      irqSync2_ff <= irqSync1_ff;
      irqPrev_ff <= irqSync2_ff;
      stbySync1_ff <= hwStandby;
      stbySync2_ff <= stbySync1_ff;
    end
  end

  // APB decode; one wait-free access, answer prepared in setup
  assign setupRd = psel && !penable;
  assign wrEn = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign rdDone = psel && penable && pready_ff && !pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `IPS_OFS_SYS_CTL: rdMux[7:0] = sysCtl_ff;
      `IPS_OFS_PRIO_A: rdMux[7:0] = prioA_ff;
      `IPS_OFS_PRIO_B: rdMux[7:0] = prioB_ff;
      `IPS_OFS_PRIO_C: rdMux[7:0] = prioC_ff;
      `IPS_OFS_EXT_EN: rdMux[7:0] = extEn_ff;
      `IPS_OFS_SENSE: rdMux[15:0] = sense_ff;
      `IPS_OFS_FLAGS: rdMux[7:0] = flags_ff;
      default: mapped = 1'b0;
    endcase
  end

  // Answer lines; unmapped addresses give pslverr and zero data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setupRd;
      pslverr_ff <= setupRd && !mapped;
      if (setupRd)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // Control mode; prohibited codes are refused and the old mode kept
  // system control init
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sysCtl_ff <= `IPS_RST_SYS_CTL;
    else if (stbySync2_ff)
      sysCtl_ff <= `IPS_RST_SYS_CTL;
    else if (wrEn && paddr == `IPS_OFS_SYS_CTL && !pwdata[`IPS_SYS_MODE_HI])
      sysCtl_ff <= pwdata[7:0] & `IPS_SYS_WMASK;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prioA_ff <= `IPS_RST_BYTE;
      prioB_ff <= `IPS_RST_BYTE;
      prioC_ff <= `IPS_RST_BYTE;
    end
    else if (stbySync2_ff)
    begin
      prioA_ff <= `IPS_RST_BYTE;
      prioB_ff <= `IPS_RST_BYTE;
      prioC_ff <= `IPS_RST_BYTE;
    end
    else if (wrEn)
    begin
      if (paddr == `IPS_OFS_PRIO_A)
        prioA_ff <= pwdata[7:0];
      if (paddr == `IPS_OFS_PRIO_B)
        prioB_ff <= pwdata[7:0];
      if (paddr == `IPS_OFS_PRIO_C)
        prioC_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      extEn_ff <= `IPS_RST_BYTE;
      sense_ff <= `IPS_RST_SENSE;
    end
    else if (stbySync2_ff)
    begin
      extEn_ff <= `IPS_RST_BYTE;
      sense_ff <= `IPS_RST_SENSE;
    end
    else if (wrEn)
    begin
      if (paddr == `IPS_OFS_EXT_EN)
        extEn_ff <= pwdata[7:0];
      if (paddr == `IPS_OFS_SENSE)
        sense_ff <= pwdata[15:0];
    end
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      levelMask[i] = !sense_ff[2*i] && !sense_ff[2*i+1];
      levelSet[i] = levelMask[i] && !irqSync2_ff[i];
      edgeSet[i] = (sense_ff[2*i] && irqPrev_ff[i] && !irqSync2_ff[i])
        || (sense_ff[2*i+1] && !irqPrev_ff[i] && irqSync2_ff[i]);
      ackVec[i] = irqAck && (irqAckNum == 3'(i));
      xferVec[i] = xferAct && !xferIntSelect && (xferActNum == 3'(i));
    end
  end

  // software clear only after a read returned 1
  assign swClr = (wrEn && paddr == `IPS_OFS_FLAGS) ? (readSeen_ff & ~pwdata[7:0]) : 8'h00;

  assign clrVec = swClr | (ackVec & (~levelMask | irqSync2_ff)) | xferVec;

  // Set wins over a clear in the same cycle
  // set ignores enables
  assign nxt_flags = levelSet | edgeSet | (flags_ff & ~clrVec);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_ff <= `IPS_RST_BYTE;
    else if (stbySync2_ff)
      flags_ff <= `IPS_RST_BYTE;
    else
      flags_ff <= nxt_flags;
  end

  // bits that software has seen set; dropped once the flag falls
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      readSeen_ff <= `IPS_RST_BYTE;
    else if (stbySync2_ff)
      readSeen_ff <= `IPS_RST_BYTE; // Standby drops arming so no stale clear follows
    else if (rdDone && paddr == `IPS_OFS_FLAGS)
      readSeen_ff <= (readSeen_ff | prdata_ff[7:0]) & nxt_flags;
    else
      readSeen_ff <= readSeen_ff & nxt_flags & ~swClr;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      nmiReq_ff <= 1'b0;
    else if (sysCtl_ff[`IPS_SYS_NMI_EDGE])
      nmiReq_ff <= !nmiPrev_ff && nmiSync2_ff;
    else
      nmiReq_ff <= nmiPrev_ff && !nmiSync2_ff;
  end

  // priority A, B and C source map
  assign extLvl = {{2{prioA_ff[`IPS_PA_IRQ67]}}, {2{prioA_ff[`IPS_PA_IRQ45]}},
    {2{prioA_ff[`IPS_PA_IRQ23]}}, prioA_ff[`IPS_PA_IRQ1], prioA_ff[`IPS_PA_IRQ0]};
  assign perLvl = {prioC_ff[`IPS_PC_SER2], prioC_ff[`IPS_PC_SER1], prioC_ff[`IPS_PC_SER0],
    prioC_ff[`IPS_PC_TMR1], prioC_ff[`IPS_PC_TMR0], prioB_ff[`IPS_PB_PT2],
    prioB_ff[`IPS_PB_PT1], prioB_ff[`IPS_PB_PT0], prioB_ff[`IPS_PB_ADC],
    prioA_ff[`IPS_PA_WDOG], prioA_ff[`IPS_PA_XFER]};

  // plain mode uses the CPU mask only
  // priority mode adds user mask for level 0
  // level 1 escapes the user mask
  assign mode = (sysCtl_ff[`IPS_SYS_MODE_HI:`IPS_SYS_MODE_LO] == `IPS_MODE_PRIO)
    ? irq_prio_pkg::CTL_PRIORITY : irq_prio_pkg::CTL_PLAIN;

  always_comb
  begin
    passExt = 8'h00;
    passPer = '0;
    case (mode)
      irq_prio_pkg::CTL_PLAIN:
      begin
        passExt = {8{!cpuIMask}};
        passPer = {NP{!cpuIMask}};
      end
      irq_prio_pkg::CTL_PRIORITY:
      begin
        passExt = {8{!cpuIMask}} & (extLvl | {8{!cpuUserMask}});
        passPer = {NP{!cpuIMask}} & (perLvl | {NP{!cpuUserMask}});
      end
      default:
      begin
        passExt = 8'h00;
        passPer = '0;
      end
    endcase
  end

  // forward flag and enable with level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      extReq_ff <= 8'h00;
      extLevel_ff <= 8'h00;
      extAccept_ff <= 8'h00;
      periphLevel_ff <= '0;
      periphAccept_ff <= '0;
      ctlMode_ff <= 1'b0;
    end
    else
    begin
      extReq_ff <= flags_ff & extEn_ff;
      extLevel_ff <= extLvl;
      extAccept_ff <= flags_ff & extEn_ff & passExt;
      periphLevel_ff <= perLvl;
      periphAccept_ff <= periphReq & passPer;
      ctlMode_ff <= (mode == irq_prio_pkg::CTL_PRIORITY);
    end
  end

  // Checks on standby reinitialisation, the flag and request logic
  sys_init_a: assert property (stbySync2_ff |=> sysCtl_ff == `IPS_RST_SYS_CTL)
    else $error("system control not reinitialised by standby");
  prio_init_a: assert property (stbySync2_ff |=> (prioA_ff | prioB_ff | prioC_ff) == 8'h00)
    else $error("priority registers not cleared by standby");
  nmi_fall_a: assert property (
    (!sysCtl_ff[`IPS_SYS_NMI_EDGE] && nmiPrev_ff && !nmiSync2_ff) |=> nmiReq_ff)
    else $error("falling NMI edge missed");
  nmi_rise_a: assert property (
    (sysCtl_ff[`IPS_SYS_NMI_EDGE] && nmiPrev_ff && !nmiSync2_ff) |=> !nmiReq_ff)
    else $error("falling NMI edge reported while rising selected");
  level_set_a: assert property (
    !stbySync2_ff |=> (flags_ff & $past(levelSet)) == $past(levelSet))
    else $error("low level did not set flag");
  edge_set_a: assert property (
    !stbySync2_ff |=> (flags_ff & $past(edgeSet)) == $past(edgeSet))
    else $error("selected edge did not set flag");
  // Handshake clears in the same cycle are legal and left out of this check
  write_one_a: assert property (
    (wrEn && paddr == `IPS_OFS_FLAGS && pwdata[7:0] == 8'hFF && !stbySync2_ff)
    |=> (flags_ff & $past(flags_ff & ~ackVec & ~xferVec))
      == $past(flags_ff & ~ackVec & ~xferVec))
    else $error("writing one cleared a flag");
  edge_ack_a: assert property (!stbySync2_ff
    |=> (flags_ff & $past(ackVec & ~levelMask & ~edgeSet)) == 8'h00)
    else $error("edge flag survived exception handling");
  xfer_clr_a: assert property (!stbySync2_ff
    |=> (flags_ff & $past(xferVec & ~levelSet & ~edgeSet)) == 8'h00)
    else $error("transfer activation did not clear flag");
  fwd_gate_a: assert property (extReq_ff == $past(flags_ff & extEn_ff))
    else $error("forwarded request not flag and enable");
  plain_mask_a: assert property ((mode == irq_prio_pkg::CTL_PLAIN && cpuIMask)
    |=> extAccept_ff == 8'h00 && periphAccept_ff == '0)
    else $error("plain mode accepted a masked request");

endmodule

// [tb/irq_far_model.sv]
// Far-side model: interrupt pins, CPU mask state and the exception and
// transfer-controller handshakes; the bench calls its tasks after clk edges.
module irq_far_model
(
  // Clock
  input wire logic clk,
  // Pins
  output logic nmiPin,
  output logic [7:0] irqPin_n,
  output logic hwStandby,
  // CPU and transfer controller
  output logic cpuIMask,
  output logic cpuUserMask,
  output logic irqAck,
  output logic [2:0] irqAckNum,
  output logic xferAct,
  output logic [2:0] xferActNum,
  output logic xferIntSelect,
  output logic [10:0] periphReq
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle NMI and IRQ pins high, standby low, every peripheral requesting
  initial
  begin
    nmiPin = 1'b1;
    irqPin_n = 8'hFF;
    hwStandby = 1'b0;
    cpuIMask = 1'b0;
    cpuUserMask = 1'b0;
    irqAck = 1'b0;
    irqAckNum = 3'h0;
    xferAct = 1'b0;
    xferActNum = 3'h0;
    xferIntSelect = 1'b1;
    periphReq = 11'h7FF;
  end

  // Level changes on the pins, mask bits and peripheral requests
  task pin(input int n, input logic v);
    irqPin_n[n] <= v;
  endtask
  task nmi(input logic v);
    nmiPin <= v;
  endtask
  task mask(input logic i, input logic u);
    cpuIMask <= i;
    cpuUserMask <= u;
  endtask
  task stby(input logic v);
    hwStandby <= v;
  endtask
  task periph(input logic [10:0] v);
    periphReq <= v;
  endtask

  // One-cycle pulses; the number is inverted afterwards so stale values show
  task ack(input logic [2:0] n);
    irqAck <= 1'b1;
    irqAckNum <= n;
    @(posedge clk);
    irqAck <= 1'b0;
    irqAckNum <= ~n;
  endtask
  task xfer(input logic [2:0] n, input logic s);
    xferAct <= 1'b1;
    xferActNum <= n;
    xferIntSelect <= s;
    @(posedge clk);
    xferAct <= 1'b0;
    xferActNum <= ~n;
  endtask
endmodule

// [tb/tb_irq_priority_sense_control.sv]
// Testbench: APB register tests, NMI edges, sensing, flag clearing, masks.
// Assumes the far-side model drives the pins and CPU handshakes.
`include "irq_params_params.svh"
module tb_irq_priority_sense_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, slvErr, nmiReq, ctlMode;
  logic nmiPin, hwStandby, cpuIMask, cpuUserMask, irqAck, xferAct, xferIntSelect;
  logic [7:0] irqPin_n, extReq, extLevel, extAccept;
  logic [2:0] irqAckNum, xferActNum;
  logic [10:0] periphReq, periphLevel, periphAccept;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int nmiCnt = 0;
  // Expected {periphLevel, extLevel} per single priority bit, bit 7 first
  logic [18:0] lvlTab [24] = '{19'h1, 19'h2, 19'hC, 19'h30, 19'hC0, 19'h100, 19'h200,
    19'h0, 19'h0, 19'h400, 19'h800, 19'h1000, 19'h2000, 19'h0, 19'h0, 19'h0,
    19'h4000, 19'h8000, 19'h0, 19'h10000, 19'h20000, 19'h40000, 19'h0, 19'h0};

  always #12.5 clk = ~clk;

  irq_priority_sense_control uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nmiPin, .irqPin_n, .hwStandby, .cpuIMask,
    .cpuUserMask, .irqAck, .irqAckNum, .xferAct, .xferActNum, .xferIntSelect,
    .periphReq, .nmiReq, .extReq, .extLevel, .extAccept, .periphLevel, .periphAccept,
    .ctlMode);
  irq_far_model far (.clk, .nmiPin, .irqPin_n, .hwStandby, .cpuIMask, .cpuUserMask,
    .irqAck, .irqAckNum, .xferAct, .xferActNum, .xferIntSelect, .periphReq);

  // NMI pulse count and hang guard; a run needs well under a thousand cycles
  always @(posedge clk)
  begin
    nmiCnt <= nmiCnt + int'(nmiReq === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      complete_run();
    end
  end

  task complete_run();
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge follows so strobes never toggle twice
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits for pready however long it takes; only the hang guard ends it
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task resetVals();
    rd(`IPS_OFS_SYS_CTL, 32'h1);
    for (int i = 1; i < 7; i++)
      rd(8'(4 * i), 32'h0);
  endtask
  task nmiStep(input logic v, input int e);
    far.nmi(v);
    settle(5);
    chk(nmiCnt, e);
  endtask
  // Pin move, then read flags (arming the clear) and write zero
  task flagStep(input int n, input logic v, input logic [31:0] e);
    far.pin(n, v);
    settle(4);
    rd(`IPS_OFS_FLAGS, e);
    wr(`IPS_OFS_FLAGS, 32'h0);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    resetVals();
    // Unmapped address is refused and reads zero
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    chk(slvErr, 1'b1);
    // NMI edges with both CPU masks set
    far.mask(1'b1, 1'b1);
    nmiStep(1'b0, 1);
    nmiStep(1'b1, 1);
    wr(`IPS_OFS_SYS_CTL, 32'h09);
    nmiStep(1'b0, 1);
    nmiStep(1'b1, 2);
    // Mode 1, then prohibited modes dropped
    wr(`IPS_OFS_SYS_CTL, 32'h99);
    wr(`IPS_OFS_SYS_CTL, 32'hA9);
    wr(`IPS_OFS_SYS_CTL, 32'hB9);
    rd(`IPS_OFS_SYS_CTL, 32'h99);
    chk(ctlMode, 1'b1);
    wr(`IPS_OFS_SYS_CTL, 32'h01);
    settle(2);
    chk(ctlMode, 1'b0);
    // Each priority bit against the sources it governs
    for (int r = 0; r < 3; r++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        wr(8'(4 + 4 * r), 32'h1 << b);
        settle(2);
        chk({periphLevel, extLevel}, lvlTab[8 * r + 7 - b]);
      end
      rd(8'(4 + 4 * r), 32'h1);
      wr(8'(4 + 4 * r), 32'h0);
    end
    // Edge modes on IRQ3 with its enable off
    for (int m = 1; m < 4; m++)
    begin
      wr(`IPS_OFS_SENSE, 32'(m) << 6);
      flagStep(3, 1'b0, 32'(m % 2) << 3);
      flagStep(3, 1'b1, 32'(m / 2) << 3);
    end
    // Zero write without a prior read, then ones after a read, keep the flag
    far.pin(3, 1'b0);
    settle(4);
    wr(`IPS_OFS_FLAGS, 32'h0);
    rd(`IPS_OFS_FLAGS, 32'h8);
    wr(`IPS_OFS_FLAGS, 32'hFF);
    rd(`IPS_OFS_FLAGS, 32'h8);
    wr(`IPS_OFS_FLAGS, 32'h0);
    rd(`IPS_OFS_FLAGS, 32'h0);
    // Exception handling and transfer activation in edge mode
    far.pin(3, 1'b1);
    settle(4);
    far.ack(3'h2);
    rd(`IPS_OFS_FLAGS, 32'h8);
    far.ack(3'h3);
    rd(`IPS_OFS_FLAGS, 32'h0);
    far.pin(3, 1'b0);
    settle(4);
    far.xfer(3'h3, 1'b1);
    rd(`IPS_OFS_FLAGS, 32'h8);
    far.xfer(3'h3, 1'b0);
    rd(`IPS_OFS_FLAGS, 32'h0);
    // Level mode with the pin held low, enable and masking
    wr(`IPS_OFS_SENSE, 32'h0);
    settle(3);
    rd(`IPS_OFS_FLAGS, 32'h8);
    chk(extReq, 8'h00);
    wr(`IPS_OFS_EXT_EN, 32'h08);
    far.mask(1'b0, 1'b1);
    settle(3);
    chk({extReq, extAccept, periphAccept}, {8'h08, 8'h08, 11'h7FF});
    far.mask(1'b1, 1'b0);
    settle(3);
    chk({extAccept, periphAccept}, 19'h0);
    wr(`IPS_OFS_SYS_CTL, 32'h11);
    far.mask(1'b0, 1'b1);
    settle(3);
    chk(extAccept, 8'h00);
    wr(`IPS_OFS_PRIO_A, 32'h20);
    settle(3);
    chk({extLevel, extAccept, periphAccept}, {8'h0C, 8'h08, 11'h0});
    // Converter at level 1 passes the user mask, transfer source at level 0 does not
    wr(`IPS_OFS_PRIO_B, 32'h40);
    far.periph(11'h005);
    settle(3);
    chk(periphAccept, 11'h004);
    // Level-mode clear needs the pin high at acknowledge
    far.ack(3'h3);
    rd(`IPS_OFS_FLAGS, 32'h8);
    far.pin(3, 1'b1);
    settle(4);
    rd(`IPS_OFS_FLAGS, 32'h8);
    far.ack(3'h3);
    rd(`IPS_OFS_FLAGS, 32'h0);
    chk(extReq, 8'h00);
    // Hardware standby returns every register to its reset value
    wr(`IPS_OFS_SENSE, 32'hFFFF);
    wr(`IPS_OFS_EXT_EN, 32'hFF);
    far.stby(1'b1);
    settle(4);
    far.stby(1'b0);
    settle(4);
    resetVals();
    complete_run();
  end
endmodule
